/* bench/core_model.sv */
// Purpose: Integer core side: issues float instructions, counts reports
// Assumes: Drives its issue pulse at the falling edge
// Notes:   Never reads condition bits, so undefined ones cannot mislead it
module core_model (
    input  wire  i_ref_clk,
    input  wire  i_error_trap,
    input  wire  i_ext_error_report,
    output logic o_fp_issue,
    output int   o_reports
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_fp_issue = 1'b0;
        o_reports = 0;
    end
    // Counts each error report it reacts to
    always @(posedge i_ref_clk) begin
        if (i_error_trap || i_ext_error_report) o_reports <= o_reports + 1;
    end
    // One float instruction issued for one cycle
    task issue();
        @(negedge i_ref_clk);
        o_fp_issue = 1'b1;
        @(negedge i_ref_clk);
        o_fp_issue = 1'b0;
    endtask
endmodule

/* bench/fpu_status_sva.sv */
// Purpose: Port checks of the float status-word logic
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound into every instance of the design
module fpu_status_sva (
    input wire        i_ref_clk, i_srst, i_op_valid, i_rem_complete, i_trig_too_large, i_round_up,
    input wire        i_class_sign, i_stack_fault, i_stack_overflow, i_mask_load, i_fp_issue,
    input wire        i_numeric_error_enable, o_error_summary, o_float_error_out_n,
    input wire        o_error_trap, o_ext_error_report,
    input wire [3:0]  i_op_kind,
    input wire [2:0]  i_quotient, i_class,
    input wire [1:0]  i_cmp_result,
    input wire [5:0]  i_exc_detect, i_mask_value, o_exc_mask,
    input wire [31:0] i_op_addr, o_instr_ptr,
    input wire [15:0] o_fpu_status
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    wire [15:0] s  = o_fpu_status;
    wire        ok = i_op_valid && !i_stack_fault;
    reg  [1:0]  cmp_q;
    // Last compare code, for the encoding check
    always @(posedge i_ref_clk) begin
        cmp_q <= i_cmp_result;
    end
    AST_SUMMARY: assert property (s[7] == |(s[5:0] & ~o_exc_mask)) else $error("summary bit wrong");
    AST_BUSY: assert property (s[15] == s[7] && o_error_summary == s[7]) else $error("busy copy wrong");
    AST_PIN: assert property (o_float_error_out_n == !s[7]) else $error("error pin wrong");
    AST_REM_DONE: assert property (ok && i_op_kind == 4'h1 && i_rem_complete |=> !s[10]
        && {s[8], s[14], s[9]} == $past(i_quotient)) else $error("quotient bits wrong");
    AST_REM_PART: assert property (ok && i_op_kind == 4'h1 && !i_rem_complete |=> s[10]
        && $stable({s[14], s[8]})) else $error("partial step wrong");
    AST_CMP: assert property (ok && i_op_kind == 4'h3 |=> {s[14], s[10], s[8]}
        == {cmp_q[1], &cmp_q, cmp_q[0]}) else $error("compare code wrong");
    AST_CLASS: assert property (ok && i_op_kind == 4'h4 |=> {s[14], s[10], s[8]} == $past(i_class)
        && s[9] == $past(i_class_sign)) else $error("class code wrong");
    AST_TRIG: assert property (ok && i_op_kind == 4'h2 |=> s[10] == $past(i_trig_too_large))
        else $error("reduction bit wrong");
    AST_ROUND: assert property (ok && i_op_kind == 4'h5 |=> s[9] == (s[5] && $past(i_round_up)))
        else $error("roundup bit wrong");
    AST_STACK: assert property (i_op_valid && i_stack_fault && i_op_kind != 4'h6 |=> s[6]
        && s[9] == $past(i_stack_overflow)) else $error("stack flag wrong");
    AST_FLAG: assert property (i_op_valid && i_op_kind != 4'h6 |=> (s[5:0] & $past(i_exc_detect))
        == $past(i_exc_detect)) else $error("flag not set");
    AST_MASK: assert property (i_mask_load |=> o_exc_mask == $past(i_mask_value)) else $error("mask wrong");
    AST_TRAP: assert property (i_fp_issue && o_error_summary |=> o_error_trap == $past(i_numeric_error_enable)
        && o_ext_error_report != $past(i_numeric_error_enable)) else $error("report wrong");
    AST_QUIET: assert property (!(i_fp_issue && o_error_summary) |=> !o_error_trap && !o_ext_error_report)
        else $error("spurious report");
    AST_PTR: assert property (i_op_valid && |i_exc_detect |=> o_instr_ptr == $past(i_op_addr))
        else $error("pointer wrong");
    COV_ISSUE: cover property (i_fp_issue && o_error_summary);
    COV_REM: cover property (ok && i_op_kind == 4'h1 && i_rem_complete);
    COV_ENV: cover property (i_op_valid && i_op_kind == 4'h6 ##1 !o_float_error_out_n);
endmodule

bind fpu_status_condition_logic fpu_status_sva chk_u (.*);

/* bench/testbench.sv */
// Purpose: Self-checking bench of the float status-word logic
// Assumes: Inputs change at the falling edge only
// Notes:   Expected words are queued by the driver, checked by a monitor
`include "fpu_status_defs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 0, i_srst = 1, i_op_valid = 0, i_rem_complete = 0, i_trig_too_large = 0, i_round_up = 0;
    logic i_class_sign = 0, i_stack_fault = 0, i_stack_overflow = 0, i_operand_valid = 0, i_mask_load = 0;
    logic i_numeric_error_enable = 0, op_q = 0, iss_q = 0;
    logic [3:0]  i_op_kind = 0;
    logic [2:0]  i_quotient = 0, i_class = 0, i_stack_top = 0;
    logic [1:0]  i_cmp_result = 0;
    logic [5:0]  i_exc_detect = 0, i_mask_value = 0;
    logic [15:0] i_env_status = 0;
    logic [31:0] i_op_addr = 0, i_operand_addr = 0, rng = 32'h4318;
    wire  [15:0] o_fpu_status;
    wire  [5:0]  o_exc_mask;
    wire  [31:0] o_instr_ptr, o_data_ptr;
    wire         o_error_summary, o_float_error_out_n, o_error_trap, o_ext_error_report, i_fp_issue;
    int          failures = 0, cmp_count = 0, reports;
    logic [31:0] sq[$];
    logic [1:0]  pq[$];
    fpu_status_condition_logic dut_u (.*);
    core_model core_u (.i_ref_clk(i_ref_clk), .i_error_trap(o_error_trap), .i_ext_error_report(o_ext_error_report),
                       .o_fp_issue(i_fp_issue), .o_reports(reports));
    initial forever #12.5 i_ref_clk = ~i_ref_clk;
    function logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    task cmp(input string n, input logic [63:0] e, g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk_status(input logic [31:0] n);
        cmp("status word", n[31:16], o_fpu_status & n[15:0]);
    endtask
    task complete_run();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // One operation, entered at a falling edge; expected word and bit mask queued
    task op(input logic [3:0] k, input logic [15:0] v, m);
        i_op_valid = 1;
        i_op_kind = k;
        i_stack_top = 3'(rnd());
        sq.push_back(k == `OP_ENV_LOAD ? {v, m} : {v | {2'h0, i_stack_top, 11'h0}, m | 16'h3800});
        @(negedge i_ref_clk);
        i_op_valid = 0;
        i_exc_detect = 0;
        i_stack_fault = 0;
    endtask
    task issue(input logic en, input logic [1:0] e);
        i_numeric_error_enable = en;
        pq.push_back(e);
        core_u.issue();
    endtask
    // Results are checked at the falling edge after the taking edge
    always @(posedge i_ref_clk) begin
        op_q <= i_op_valid && !i_srst;
        iss_q <= i_fp_issue && !i_srst;
    end
    always @(negedge i_ref_clk) begin
        if (op_q) chk_status(sq.pop_front());
        if (iss_q) cmp("error pulses", pq.pop_front(), {o_error_trap, o_ext_error_report});
    end
    initial begin
        repeat (4) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_srst = 0;
        @(negedge i_ref_clk);
        cmp("reset state", {16'h0, 6'h3f, 1'b1}, {o_fpu_status, o_exc_mask, o_float_error_out_n});
        $display("test reset done");
        i_rem_complete = 1;
        for (int q = 0; q < 8; q++) begin
            i_quotient = 3'(q);
            op(`OP_REMAINDER, {1'b0, q[1], 3'h0, 1'b0, q[0], q[2], 8'h0}, 16'h4700);
        end
        i_rem_complete = 0;
        op(`OP_REMAINDER, 16'h0400, 16'h0400);
        for (int r = 0; r < 4; r++) begin
            i_cmp_result = 2'(r);
            op(`OP_COMPARE, {1'b0, r[1], 3'h0, &r[1:0], 1'b0, r[0], 8'h0}, 16'h4500);
        end
        for (int c = 0; c < 7; c++) begin
            i_class = 3'(c);
            i_class_sign = c[0] ^ c[1];
            op(`OP_CLASSIFY, {1'b0, c[2], 3'h0, c[1], c[0] ^ c[1], c[0], 8'h0}, 16'h4700);
        end
        $display("test codes done");
        i_trig_too_large = 1;
        op(`OP_TRIG, 16'h0400, 16'h0400);
        i_trig_too_large = 0;
        i_round_up = 1;
        i_exc_detect = 6'h20;
        op(`OP_TRIG, 16'h0220, 16'h0620);
        i_round_up = 0;
        op(`OP_ARITH, 16'h0020, 16'h0220);
        i_op_addr = rnd();
        i_operand_addr = rnd();
        i_operand_valid = 1;
        i_stack_fault = 1;
        i_stack_overflow = 1;
        i_exc_detect = 6'h01;
        op(`OP_ARITH, 16'h0261, 16'h02e1);
        cmp("pointers", {i_op_addr, i_operand_addr}, {o_instr_ptr, o_data_ptr});
        i_stack_fault = 1;
        i_stack_overflow = 0;
        i_exc_detect = 6'h01;
        op(`OP_ARITH, 16'h0041, 16'h0241);
        $display("test flags done");
        issue(1, 2'h0);
        i_mask_value = 6'h3e;
        i_mask_load = 1;
        @(negedge i_ref_clk);
        i_mask_load = 0;
        cmp("error pin", 1'b0, o_float_error_out_n);
        issue(1, 2'h2);
        issue(0, 2'h1);
        op(`OP_CLEAR_EXC, 16'h0000, 16'h80bf);
        cmp("reports", 32'd2, reports);
        op(`OP_CC_UNDEF, 16'h0000, 16'h0000);
        i_env_status = 16'h8080;
        op(`OP_ENV_LOAD, 16'h0000, 16'hffff);
        repeat (4) begin
            i_env_status = 16'(rnd());
            op(`OP_ENV_LOAD, {i_env_status[0], i_env_status[14:8], i_env_status[0], i_env_status[6:0]},
               16'hffff);
        end
        i_env_status = 16'h0001;
        op(`OP_ENV_LOAD, 16'h8081, 16'hffff);
        cmp("error pin", 1'b0, o_float_error_out_n);
        i_srst = 1;
        repeat (2) @(negedge i_ref_clk);
        i_srst = 0;
        @(negedge i_ref_clk);
        cmp("reset again", {16'h0, 6'h3f, 1'b1}, {o_fpu_status, o_exc_mask, o_float_error_out_n});
        $display("test error env done");
        complete_run();
    end
    initial begin
        #1000000;
        failures++;
        complete_run();
    end
endmodule

/* rtl/fpu_status_condition_logic.v */
// Purpose: Status word, condition codes, exception flags and error
//          output of an embedded floating point unit
// Assumes: All inputs synchronous to i_ref_clk (40 MHz); the core
//          presents one completed operation per i_op_valid pulse
// Notes:   Error summary, busy copy and error pin are combinational
//          from the flag and mask flops so they never go stale

`include "fpu_status_defs.vh"

// Overview of operation
// - An incomplete partial-remainder step sets cond_bit_2 to one, the partial remainder staying on the stack.
// - A trig operation with a too-large stack-top operand sets the reduction bit and leaves the operand unchanged.
// - While the precision flag is set, cond_bit_1 records whether the last rounding went upward.
// - A complete reduction clears cond_bit_2 and puts quotient bits 2,1,0 into cond_bit_0, cond_bit_3, cond_bit_1.
// - Compare writes C3,C2,C0 as 000 greater, 001 less, 100 equal and 111 unordered.
// - Classify writes class code into C3,C2,C0 and the sign into cond_bit_1.
// - Status bit 7 is set exactly when some flag in bits 0-5 is set with its mask clear.
// - The active-low error output is asserted whenever the error summary is set.
// - Status bit 6 marks stack overflow or underflow, with bit 9 one for overflow and zero for underflow.
// - Each exception detected during any operation but an environment load sets its matching flag in bits 0-5.
// - Each flag has its own mask bit, and a masked flag never raises an error.
// - With an error pending, the next float or wait issue raises vector 16 or an external report per the enable.
// - An exception captures the faulting instruction address and its operand address.
// - On environment load, bits 7 and 15 are recomputed from flags and masks, not loaded.
// - If that recomputed summary is set, the error output asserts at once.
module fpu_status_condition_logic (
    input  wire        i_ref_clk,
    input  wire        i_srst,
    input  wire        i_op_valid,
    input  wire [3:0]  i_op_kind,
    input  wire        i_rem_complete,
    input  wire [2:0]  i_quotient,
    input  wire        i_trig_too_large,
    input  wire        i_round_up,
    input  wire [1:0]  i_cmp_result,
    input  wire [2:0]  i_class,
    input  wire        i_class_sign,
    input  wire [5:0]  i_exc_detect,
    input  wire        i_stack_fault,
    input  wire        i_stack_overflow,
    input  wire [31:0] i_op_addr,
    input  wire [31:0] i_operand_addr,
    input  wire        i_operand_valid,
    input  wire [15:0] i_env_status,
    input  wire        i_mask_load,
    input  wire [5:0]  i_mask_value,
    input  wire [2:0]  i_stack_top,
    input  wire        i_numeric_error_enable,
    input  wire        i_fp_issue,
    output wire [15:0] o_fpu_status,
    output wire [5:0]  o_exc_mask,
    output wire        o_error_summary,
    output wire        o_float_error_out_n,
    output reg         o_error_trap,
    output reg         o_ext_error_report,
    output reg  [31:0] o_instr_ptr,
    output reg  [31:0] o_data_ptr
);

    // Architectural state
    reg  [5:0] flags_q;
    wire [5:0] flags_d;
    reg  [5:0] mask_q;
    reg        stack_fault_flag_q;
    reg        stack_fault_flag_d;
    reg  [3:0] cc_q;
    reg  [3:0] cc_d;
    reg  [2:0] top_q;
    reg  [2:0] top_d;

    // Decoded helpers
    wire       op_any_exc;
    wire [5:0] new_flags;
    wire       error_summary;
    wire       env_load_op;
    wire       clear_exceptions_op;

    // Summary decode, used only for the live summary from the flops
    function summary_of;
        input [5:0] flags;
        input [5:0] masks;
        begin
            summary_of = |(flags & ~masks);
        end
    endfunction

    // Operation decode, shared by the flag and stack paths
    function op_is;
        input       valid;
        input [3:0] kind;
        input [3:0] want;
        begin
            op_is = valid && (kind == want);
        end
    endfunction

    // Strobes of the two operations that rewrite whole groups of bits
    assign env_load_op         = op_is(i_op_valid, i_op_kind, `OP_ENV_LOAD);
    assign clear_exceptions_op = op_is(i_op_valid, i_op_kind, `OP_CLEAR_EXC);

    // Exceptions reported by the current operation
    assign new_flags  = i_op_valid ? i_exc_detect : 6'h00;
    assign op_any_exc = |new_flags;

    // Flag precedence, highest first:
    //   1. Environment load replaces the whole group from the memory image
    //   2. A detected exception sets its flag
    //   3. A clear-exceptions operation wipes the flag
    //   4. Otherwise the flag holds its value
    // Detection wins over a clear in the same operation so that an event
    // arriving together with a clear is never lost; the flags are sticky
    // and only software clears them.

    // Per-flag next value: env load replaces, detect sets, clear op wipes
    genvar gi;
    generate
        for (gi = 0; gi < `EXC_COUNT; gi = gi + 1) begin : g_flag
            assign flags_d[gi] = env_load_op         ? i_env_status[`SW_FLAGS_LSB + gi] :
                                 new_flags[gi]       ? 1'b1 :
                                 clear_exceptions_op ? 1'b0 :
                                 flags_q[gi];
        end
    endgenerate

    // Stack flag follows the same load, set and clear order
    always @* begin
        if (env_load_op) begin
            stack_fault_flag_d = i_env_status[`SW_STACK_BIT];
        end else if (i_op_valid && i_stack_fault) begin
            stack_fault_flag_d = 1'b1;
        end else if (clear_exceptions_op) begin
            stack_fault_flag_d = 1'b0;
        end else begin
            stack_fault_flag_d = stack_fault_flag_q;
        end
    end

    // Condition code writers, by operation kind:
    //   remainder  - reduction bit, and quotient bits when complete
    //   trig       - reduction bit, roundup only when the operand fitted
    //   compare    - three-bit order code, roundup bit untouched
    //   classify   - three-bit class code plus the operand sign
    //   arith      - roundup bit only
    //   env load   - every bit and the stack top taken from the image
    //   others     - bits kept; software must not rely on them
    // A stack fault on any operation but a load then overrides the
    // roundup bit with the overflow direction, last writer wins.
    // The stack top follows the core on every non-load operation.

    // Condition code encoding per operation kind, stored as {C3,C2,C1,C0}
    always @* begin
        cc_d  = cc_q;
        top_d = top_q;
        if (i_op_valid) begin
            case (i_op_kind)
                `OP_REMAINDER: begin
                    if (!i_rem_complete) begin
                        cc_d[2] = 1'b1;
                    end else begin
                        cc_d[2] = 1'b0;
                        cc_d[0] = i_quotient[2];
                        cc_d[3] = i_quotient[1];
                        cc_d[1] = i_quotient[0];
                    end
                end
                `OP_TRIG: begin
                    cc_d[2] = i_trig_too_large;
                    if (!i_trig_too_large) begin
                        cc_d[1] = flags_d[`EXC_PRECISION] & i_round_up;
                    end
                end
                `OP_COMPARE: begin
                    case (i_cmp_result)
                        `CMP_GREATER: {cc_d[3], cc_d[2], cc_d[0]} = 3'h0;
                        `CMP_LESS:    {cc_d[3], cc_d[2], cc_d[0]} = 3'h1;
                        `CMP_EQUAL:   {cc_d[3], cc_d[2], cc_d[0]} = 3'h4;
                        default:      {cc_d[3], cc_d[2], cc_d[0]} = 3'h7;
                    endcase
                end
                `OP_CLASSIFY: begin
                    {cc_d[3], cc_d[2], cc_d[0]} = i_class;
                    cc_d[1] = i_class_sign;
                end
                `OP_ARITH: begin
                    cc_d[1] = flags_d[`EXC_PRECISION] & i_round_up;
                end
                `OP_ENV_LOAD: begin
                    cc_d  = {i_env_status[`SW_C3_BIT], i_env_status[`SW_C2_BIT],
                             i_env_status[`SW_C1_BIT], i_env_status[`SW_C0_BIT]};
                    top_d = i_env_status[`SW_TOP_MSB:`SW_TOP_LSB];
                end
                default: begin
                    // Undefined-code operations keep the old bits
                    cc_d = cc_q;
                end
            endcase
            // Stack fault overrides C1 with the overflow direction
            if (i_stack_fault && i_op_kind != `OP_ENV_LOAD) begin
                cc_d[1] = i_stack_overflow;
            end
            if (i_op_kind != `OP_ENV_LOAD) begin
                top_d = i_stack_top;
            end
        end
    end

    // Reset state: no flags, no stack fault, codes and top cleared, all
    // exceptions masked, so the error pin rests high and no report can
    // be raised until software unmasks something.
    // Reset is synchronous; the first operation may be given in any
    // cycle in which reset is low.

    // State registers
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            flags_q            <= `SW_RESET_FLAGS;
            stack_fault_flag_q <= 1'b0;
            cc_q               <= `SW_RESET_CC;
            top_q              <= `SW_RESET_TOP;
        end else begin
            flags_q            <= flags_d;
            stack_fault_flag_q <= stack_fault_flag_d;
            cc_q               <= cc_d;
            top_q              <= top_d;
        end
    end

    // Exception masks from the control word
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            mask_q <= `CW_RESET_MASK;
        end else if (i_mask_load) begin
            mask_q <= i_mask_value;
        end
    end

    // Summary hazard: a stored summary bit could disagree with the flags
    // after a load or a mask change. Deriving it from the flag and mask
    // flops means a load that leaves an unmasked flag set drives the
    // error pin low in the very next cycle, with no instruction needed.

    // Live summary: recomputed from flops, never loaded from memory
    assign error_summary       = summary_of(flags_q, mask_q);
    assign o_error_summary     = error_summary;
    assign o_float_error_out_n = ~error_summary;
    assign o_exc_mask          = mask_q;

    // Status word layout:
    //   15     busy copy of the summary
    //   14     cond_bit_3
    //   13:11  stack top pointer
    //   10     cond_bit_2
    //   9      cond_bit_1
    //   8      cond_bit_0
    //   7      error summary
    //   6      stack fault flag
    //   5:0    exception flags, bit 0 invalid operation, bit 5 precision

    // Assembled status word; bit 15 mirrors the summary
    assign o_fpu_status = {error_summary, cc_q[3], top_q, cc_q[2], cc_q[1], cc_q[0],
                           error_summary, stack_fault_flag_q, flags_q};

    // Reports are one-cycle pulses, one per issue seen while an error is
    // pending; the enable picks the trap or the external report, never
    // both. The core keeps issuing until software resolves the error.

    // Pending error is reported on the next float or wait issue
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_error_trap       <= 1'b0;
            o_ext_error_report <= 1'b0;
        end else begin
            o_error_trap       <= i_fp_issue & error_summary & i_numeric_error_enable;
            o_ext_error_report <= i_fp_issue & error_summary & ~i_numeric_error_enable;
        end
    end

    // Pointers only move on an exception, so a handler always sees the
    // faulting operation even after later clean operations. An operation
    // without a memory operand leaves a zero data pointer.

    // Capture the faulting instruction and operand addresses
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_instr_ptr <= 32'h0000_0000;
            o_data_ptr  <= 32'h0000_0000;
        end else if (op_any_exc || (i_op_valid && i_stack_fault)) begin
            o_instr_ptr <= i_op_addr;
            o_data_ptr  <= i_operand_valid ? i_operand_addr : 32'h0000_0000;
        end
    end

endmodule

/* rtl/fpu_status_defs.vh */
// Purpose: Constants for the floating point status-word logic
// Assumes: Included by rtl/fpu_status_condition_logic.v and by the testbench
// Notes:   Bit positions refer to the 16-bit status word
`ifndef FPU_STATUS_DEFS_VH
`define FPU_STATUS_DEFS_VH

// Status word field positions
`define SW_FLAGS_LSB   0
`define SW_FLAGS_MSB   5
`define SW_STACK_BIT   6
`define SW_ES_BIT      7
`define SW_C0_BIT      8
`define SW_C1_BIT      9
`define SW_C2_BIT      10
`define SW_TOP_LSB     11
`define SW_TOP_MSB     13
`define SW_C3_BIT      14
`define SW_BUSY_BIT    15

// Exception flag indices within bits 0-5
`define EXC_INVALID    0
`define EXC_PRECISION  5
`define EXC_COUNT      6

// Reset values
`define SW_RESET_FLAGS 6'h00
`define SW_RESET_CC    4'h0
`define SW_RESET_TOP   3'h0
`define CW_RESET_MASK  6'h3f

// Operation kinds on i_op_kind
`define OP_NONE        4'h0
`define OP_REMAINDER   4'h1
`define OP_TRIG        4'h2
`define OP_COMPARE     4'h3
`define OP_CLASSIFY    4'h4
`define OP_ARITH       4'h5
`define OP_ENV_LOAD    4'h6
`define OP_CLEAR_EXC   4'h7
`define OP_CC_UNDEF    4'h8

// Comparison result codes on i_cmp_result
`define CMP_GREATER    2'h0
`define CMP_LESS       2'h1
`define CMP_EQUAL      2'h2
`define CMP_UNORDERED  2'h3

// Classification codes on i_class, already in C3,C2,C0 order
`define CLS_UNSUPPORTED 3'h0
`define CLS_NAN         3'h1
`define CLS_NORMAL      3'h2
`define CLS_INFINITY    3'h3
`define CLS_ZERO        3'h4
`define CLS_EMPTY       3'h5
`define CLS_DENORMAL    3'h6

`endif
